/* core/eag_consts.vh */
// Constants for the energy accumulation, gain and channel configuration block.
// Included by the block's design file; holds definitions only.
`ifndef EAG_CONSTS_VH
`define EAG_CONSTS_VH

// Register indices; the byte address on the bus is four times the index.
`define EAG_IDX_ACCUM_MODE 10'h00F
`define EAG_IDX_GAIN 10'h01B
`define EAG_IDX_CHAN_SEL 10'h01C
`define EAG_IDX_IRQ_STATUS 10'h020
`define EAG_IDX_IRQ_ENABLE 10'h021
`define EAG_IDX_IRQ_CLEAR 10'h022

// Accumulation mode register fields.
`define EAG_ACC_ABS_ACTIVE 0
`define EAG_ACC_POS_ONLY 1
`define EAG_ACC_SIGN_ADJ_REACT 2
`define EAG_ACC_ABS_REACT 3
`define EAG_ACC_ACT_EDGE 4
`define EAG_ACC_REACT_EDGE 5
`define EAG_ACC_FAULT_EDGE 6
`define EAG_ACC_TAMPER_IND 7
`define EAG_ACC_WR_MASK 8'h7F

// Gain register fields.
`define EAG_GAIN_CUR_LSB 0
`define EAG_GAIN_PULSE_SIGN 3
`define EAG_GAIN_VOLT_LSB 5
`define EAG_GAIN_WR_MASK 8'hEF
`define EAG_GAIN_MAX_CODE 3'h4

// Channel selection register fields.
`define EAG_CSEL_CUR_GND 2
`define EAG_CSEL_VOLT_GND 3
`define EAG_CSEL_INPUT_LSB 4
`define EAG_CSEL_WR_MASK 8'hFC
`define EAG_CSEL_FORCE_A 2'h1
`define EAG_CSEL_FORCE_B 2'h2

// Interrupt status, enable and clear bit positions.
`define EAG_IRQ_ACTIVE_SIGN 0
`define EAG_IRQ_REACT_SIGN 1
`define EAG_IRQ_FAULT 2
`define EAG_IRQ_WIDTH 3

// Reset values.
`define EAG_RST_BYTE 8'h00
`define EAG_RST_IRQ 3'h0

`endif

/* core/eag_cfg.v */
// Configuration registers for the energy accumulation front end, with the
// accumulation-mode datapath, power sign and fault event detection and
// a sticky interrupt status behind an APB slave.
// Assumes power samples, pulses and the fault level come from logic on pclk.
`timescale 1ns/1ps
`include "eag_consts.vh"

// What this block does
// - Top accumulation-mode bit reads which current input, A=0 B=1, is used.
// - Fault edge bit 0 flags entering fault mode, 1 flags return to normal.
// - Reactive edge bit 0 flags positive-to-negative, 1 negative-to-positive.
// - Active edge bit 0 flags positive-to-negative, 1 negative-to-positive.
// - Reactive absolute mode accumulates reactive power magnitude.
// - Sign-adjusted mode inverts reactive power while active power is negative.
// - Positive-only mode accumulates only positive active power.
// - Active absolute mode accumulates active power magnitude.
// - Gain bits 7 to 5 set voltage gain 1 to 16 by codes 0 to 4.
// - Gain bit 3 picks sign detection on filtered power or per pulse.
// - Gain bits 2 to 0 set current gain 1 to 16 by codes 0 to 4.
// - Selection bits 5 to 4: 01 forces A, 10 forces B, else tamper logic.
// - Channel-selection bit 3 grounds the voltage input.
// - Channel-selection bit 2 grounds both current inputs.
// - Active sign status flag sets on the selected active sign change.
// - Status flags raise the interrupt only while their enable bit is set.
module eag_cfg #(
   parameter PW = 24
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire sample_valid,
   input wire signed [PW-1:0] active_power,
   input wire signed [PW-1:0] reactive_power,
   input wire active_pulse,
   input wire active_pulse_neg,
   input wire reactive_pulse,
   input wire reactive_pulse_neg,
   input wire fault_mode,
   input wire tamper_picks_b,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   output reg accum_valid,
   output reg signed [PW-1:0] active_accum_term,
   output reg signed [PW-1:0] reactive_accum_term,
   output reg [2:0] voltage_gain_code,
   output reg [2:0] current_gain_code,
   output reg tamper_current_input_ind,
   output reg voltage_input_ground,
   output reg current_inputs_ground,
   output reg irq
);

   reg [7:0] accumulation_mode_cfg;
   reg [7:0] channel_gain_cfg;
   reg [7:0] current_channel_select_cfg;
   reg [`EAG_IRQ_WIDTH-1:0] irq_status;
   reg [`EAG_IRQ_WIDTH-1:0] irq_enable;
   // Settings as sampled at the last power sample.
   reg [7:0] acc_live;
   reg [7:0] gain_live;
   reg [7:0] csel_live;
   reg act_neg;
   reg react_neg;
   reg sign_seen;
   reg fault_prev;
   reg fault_seen;

   wire setup = psel & ~penable;
   wire wr_en = psel & penable & pwrite;
   wire [9:0] idx = paddr[11:2];

   // APB write side: registers update at the access edge.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         accumulation_mode_cfg <= `EAG_RST_BYTE;
         channel_gain_cfg <= `EAG_RST_BYTE;
         current_channel_select_cfg <= `EAG_RST_BYTE;
         irq_enable <= `EAG_RST_IRQ;
      end else if (wr_en) begin
         case (idx)
            `EAG_IDX_ACCUM_MODE: begin
               accumulation_mode_cfg <= pwdata[7:0] & `EAG_ACC_WR_MASK;
            end
            `EAG_IDX_GAIN: begin
               channel_gain_cfg <= pwdata[7:0] & `EAG_GAIN_WR_MASK;
            end
            `EAG_IDX_CHAN_SEL: begin
               current_channel_select_cfg <= pwdata[7:0] & `EAG_CSEL_WR_MASK;
            end
            `EAG_IDX_IRQ_ENABLE: begin
               irq_enable <= pwdata[`EAG_IRQ_WIDTH-1:0];
            end
            default: begin
               irq_enable <= irq_enable;
            end
         endcase
      end
   end

   wire [1:0] sel_code = csel_live[`EAG_CSEL_INPUT_LSB+1:`EAG_CSEL_INPUT_LSB];
   wire use_b = (sel_code == `EAG_CSEL_FORCE_B) ? 1'b1 :
                (sel_code == `EAG_CSEL_FORCE_A) ? 1'b0 : tamper_picks_b;

   // APB read side: data and answer are prepared in the setup cycle.
   reg [31:0] next_prdata;
   reg next_err;
   always @* begin
      next_prdata = 32'h00000000;
      next_err = 1'b0;
      case (idx)
         `EAG_IDX_ACCUM_MODE: begin
            next_prdata[7:0] = {tamper_current_input_ind, accumulation_mode_cfg[6:0]};
         end
         `EAG_IDX_GAIN: begin
            next_prdata[7:0] = channel_gain_cfg;
         end
         `EAG_IDX_CHAN_SEL: begin
            next_prdata[7:0] = current_channel_select_cfg;
         end
         `EAG_IDX_IRQ_STATUS: begin
            next_prdata[`EAG_IRQ_WIDTH-1:0] = irq_status;
         end
         `EAG_IDX_IRQ_ENABLE: begin
            next_prdata[`EAG_IRQ_WIDTH-1:0] = irq_enable;
         end
         `EAG_IDX_IRQ_CLEAR: begin
            next_prdata = 32'h00000000;
         end
         default: begin
            next_err = 1'b1;
         end
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         pslverr <= setup & next_err;
         if (setup) begin
            prdata <= next_prdata;
         end
      end
   end

   // Accumulation terms, one per power sample.
   wire signed [PW-1:0] act_mag = active_power[PW-1] ? -active_power : active_power;
   wire signed [PW-1:0] react_mag = reactive_power[PW-1] ? -reactive_power : reactive_power;
   reg signed [PW-1:0] next_act;
   reg signed [PW-1:0] next_react;
   always @* begin
      next_act = active_power;
      if (acc_live[`EAG_ACC_ABS_ACTIVE]) begin
         next_act = act_mag;
      end else if (acc_live[`EAG_ACC_POS_ONLY] && active_power[PW-1]) begin
         next_act = {PW{1'b0}};
      end
      next_react = reactive_power;
      if (acc_live[`EAG_ACC_ABS_REACT]) begin
         next_react = react_mag;
      end else if (acc_live[`EAG_ACC_SIGN_ADJ_REACT] && active_power[PW-1]) begin
         next_react = -reactive_power;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_live <= `EAG_RST_BYTE;
         gain_live <= `EAG_RST_BYTE;
         csel_live <= `EAG_RST_BYTE;
      end else if (sample_valid) begin
         acc_live <= accumulation_mode_cfg;
         gain_live <= channel_gain_cfg;
         csel_live <= current_channel_select_cfg;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         accum_valid <= 1'b0;
         active_accum_term <= {PW{1'b0}};
         reactive_accum_term <= {PW{1'b0}};
      end else begin
         accum_valid <= sample_valid;
         if (sample_valid) begin
            active_accum_term <= next_act;
            reactive_accum_term <= next_react;
         end
      end
   end

   // Gain and input controls.
   wire [2:0] vcode = gain_live[`EAG_GAIN_VOLT_LSB+2:`EAG_GAIN_VOLT_LSB];
   wire [2:0] ccode = gain_live[`EAG_GAIN_CUR_LSB+2:`EAG_GAIN_CUR_LSB];
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         voltage_gain_code <= 3'h0;
         current_gain_code <= 3'h0;
         tamper_current_input_ind <= 1'b0;
         voltage_input_ground <= 1'b0;
         current_inputs_ground <= 1'b0;
      end else begin
         voltage_gain_code <= (vcode > `EAG_GAIN_MAX_CODE) ? `EAG_GAIN_MAX_CODE : vcode;
         current_gain_code <= (ccode > `EAG_GAIN_MAX_CODE) ? `EAG_GAIN_MAX_CODE : ccode;
         tamper_current_input_ind <= use_b;
         voltage_input_ground <= csel_live[`EAG_CSEL_VOLT_GND];
         current_inputs_ground <= csel_live[`EAG_CSEL_CUR_GND];
      end
   end

   wire per_pulse = gain_live[`EAG_GAIN_PULSE_SIGN];
   wire act_strobe = per_pulse ? active_pulse : sample_valid;
   wire react_strobe = per_pulse ? reactive_pulse : sample_valid;
   wire act_now_neg = per_pulse ? active_pulse_neg : active_power[PW-1];
   wire react_now_neg = per_pulse ? reactive_pulse_neg : reactive_power[PW-1];
   wire act_edge_sel = acc_live[`EAG_ACC_ACT_EDGE];
   wire react_edge_sel = acc_live[`EAG_ACC_REACT_EDGE];

   wire act_event = act_strobe & sign_seen & (act_neg != act_now_neg) &
                    (act_now_neg ^ act_edge_sel);
   wire react_event = react_strobe & sign_seen & (react_neg != react_now_neg) &
                      (react_now_neg ^ react_edge_sel);
   wire fault_event = fault_seen & (fault_prev != fault_mode) &
                      (fault_mode ^ acc_live[`EAG_ACC_FAULT_EDGE]);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act_neg <= 1'b0;
         react_neg <= 1'b0;
         sign_seen <= 1'b0;
         fault_prev <= 1'b0;
         fault_seen <= 1'b0;
      end else begin
         if (act_strobe) begin
            act_neg <= act_now_neg;
         end
         if (react_strobe) begin
            react_neg <= react_now_neg;
         end
         if (sample_valid) begin
            sign_seen <= 1'b1;
         end
         fault_prev <= fault_mode;
         fault_seen <= 1'b1;
      end
   end

   // Sticky status: a set in the same cycle as its clear wins.
   wire clr_wr = wr_en & (idx == `EAG_IDX_IRQ_CLEAR);
   wire [`EAG_IRQ_WIDTH-1:0] clr_bits = clr_wr ? pwdata[`EAG_IRQ_WIDTH-1:0] : `EAG_RST_IRQ;
   wire [`EAG_IRQ_WIDTH-1:0] set_bits = {fault_event, react_event, act_event};
   wire [`EAG_IRQ_WIDTH-1:0] next_status = (irq_status & ~clr_bits) | set_bits;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status <= `EAG_RST_IRQ;
         irq <= 1'b0;
      end else begin
         irq_status <= next_status;
         irq <= |(irq_status & irq_enable);
      end
   end

endmodule

/* verification/eag_cfg_properties.sv */
// Port assertions for the energy accumulation configuration block.
// Bound onto eag_cfg; needs the block's constants header on the include path.
`timescale 1ns/1ps
`include "eag_consts.vh"
module eag_cfg_properties #(
   parameter PW = 24
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire sample_valid,
   input wire accum_valid,
   input wire signed [PW-1:0] active_accum_term,
   input wire signed [PW-1:0] reactive_accum_term,
   input wire [2:0] voltage_gain_code,
   input wire [2:0] current_gain_code,
   input wire voltage_input_ground,
   input wire current_inputs_ground,
   input wire irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire [9:0] idx = paddr[11:2];
   wire hit = idx == `EAG_IDX_ACCUM_MODE || idx == `EAG_IDX_GAIN || idx == `EAG_IDX_CHAN_SEL
      || idx == `EAG_IDX_IRQ_STATUS || idx == `EAG_IDX_IRQ_ENABLE || idx == `EAG_IDX_IRQ_CLEAR;
   wire [7:0] live = {voltage_gain_code, current_gain_code, voltage_input_ground,
      current_inputs_ground};
   wire [2*PW-1:0] terms = {active_accum_term, reactive_accum_term};
   wire gains_ok = voltage_gain_code <= 3'h4 && current_gain_code <= 3'h4;
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence access_s;
      psel && penable;
   endsequence
   chk_ready_no_wait: assert property (setup_s ##1 access_s |-> pready)
      else $error("ready missing in access");
   chk_ready_access: assert property (pready |-> access_s)
      else $error("ready outside access");
   chk_err_unmapped: assert property (pready |-> pslverr == !hit)
      else $error("slave error wrong");
   chk_read_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0
      && (hit || prdata == 32'h0)) else $error("read data upper bits set");
   chk_accum_follow: assert property (sample_valid |=> accum_valid)
      else $error("no accumulate strobe");
   chk_accum_cause: assert property (accum_valid |-> $past(sample_valid))
      else $error("stray accumulate strobe");
   chk_term_hold: assert property (!accum_valid |-> $stable(terms))
      else $error("terms moved without strobe");
   chk_gain_range: assert property (gains_ok)
      else $error("gain code out of range");
   chk_live_timing: assert property ($changed(live) |->
      $past(sample_valid) || $past(sample_valid, 2)) else $error("setting moved off sample");
   chk_reset_clear: assert property ($rose(presetn) |-> !irq && !accum_valid && !live)
      else $error("outputs not clear after reset");
endmodule

bind eag_cfg eag_cfg_properties #(.PW(PW)) eag_cfg_properties_inst (.*);

/* verification/eag_cfg_tb.sv */
// Self-checking bench for the energy accumulation configuration block.
// Drives APB, power samples, pulses and the fault level directly; single clock.
`timescale 1ns/1ps
`include "eag_consts.vh"
module eag_cfg_tb;
   localparam [9:0] AM = `EAG_IDX_ACCUM_MODE;
   localparam [9:0] GN = `EAG_IDX_GAIN;
   localparam [9:0] CS = `EAG_IDX_CHAN_SEL;
   localparam [9:0] ST = `EAG_IDX_IRQ_STATUS;
   localparam [9:0] EN = `EAG_IDX_IRQ_ENABLE;
   localparam [9:0] CL = `EAG_IDX_IRQ_CLEAR;
   localparam [23:0] P5 = 24'h000005;
   localparam [23:0] P3 = 24'h000003;
   localparam [23:0] N5 = 24'hFFFFFB;
   localparam [23:0] N3 = 24'hFFFFFD;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sample_valid = 0;
   logic active_pulse = 0, active_pulse_neg = 0, reactive_pulse = 0, reactive_pulse_neg = 0;
   logic fault_mode = 0, tamper_picks_b = 0, pready, pslverr, accum_valid, irq, rerr;
   logic tamper_current_input_ind, voltage_input_ground, current_inputs_ground;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rdat;
   logic signed [23:0] active_power = 0, reactive_power = 0, ta, tr;
   logic signed [23:0] active_accum_term, reactive_accum_term;
   logic [2:0] voltage_gain_code, current_gain_code;
   logic [9:0] ix[3] = '{AM, GN, CS};
   logic [7:0] mk[3] = '{8'h7F, 8'hEF, 8'hFC};
   logic [7:0] md[6] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h04};
   int av[6] = '{-5, -5, -5, -5, -5, 5};
   int rv[6] = '{3, 3, 3, 3, -3, 3};
   int ea[6] = '{-5, 5, 0, -5, -5, 5};
   int er[6] = '{3, 3, 3, -3, 3, 3};
   int error_cnt = 0, compares = 0;

   eag_cfg #(.PW(24)) eag_cfg_inst (.*);

   initial begin
      forever #20 pclk = ~pclk;
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task apb(input logic w, input logic [9:0] i, input logic [7:0] d);
      int n;
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= {i, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rdat = prdata;
      rerr = pslverr;
      psel <= 0;
      penable <= 0;
   endtask

   task wr(input logic [9:0] i, input logic [7:0] d);
      apb(1'b1, i, d);
   endtask

   task rd(input logic [9:0] i, input logic [7:0] e);
      apb(1'b0, i, 8'h00);
      chk(rdat, {24'h0, e});
   endtask

   // Sends one power sample and keeps the terms that come back with the strobe.
   task smp(input logic signed [23:0] a, input logic signed [23:0] r);
      @(posedge pclk);
      sample_valid <= 1;
      active_power <= a;
      reactive_power <= r;
      @(posedge pclk);
      sample_valid <= 0;
      @(posedge pclk);
      chk(accum_valid, 1'b1);
      ta = active_accum_term;
      tr = reactive_accum_term;
      @(posedge pclk);
   endtask

   task pls(input logic n);
      @(posedge pclk);
      active_pulse <= 1;
      reactive_pulse <= 1;
      active_pulse_neg <= n;
      reactive_pulse_neg <= n;
      @(posedge pclk);
      active_pulse <= 0;
      reactive_pulse <= 0;
   endtask

   task summarize;
      $display("compares=%0d errors=%0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      #200000;
      error_cnt++;
      summarize();
   end

   initial begin
      logic [2:0] c;
      logic [1:0] s;
      logic e;
      repeat (10) @(posedge pclk);
      presetn <= 1;
      rd(ST, 8'h00);
      rd(EN, 8'h00);
      wr(10'h3FF, 8'hFF);
      rd(10'h3FF, 8'h00);
      chk(rerr, 1'b1);
      for (int k = 0; k < 3; k++) begin
         rd(ix[k], 8'h00);
         wr(ix[k], 8'hFF);
         rd(ix[k], mk[k]);
         wr(ix[k], 8'h00);
      end
      for (int k = 0; k < 5; k++) begin
         c = 3'(k);
         // Current gain code 0 is avoided, so that two-input parts cannot overrange.
         wr(GN, {c, 2'b00, (c == 3'h0) ? 3'h4 : c});
         smp(P5, P3);
         chk(voltage_gain_code, c);
         chk(current_gain_code, (c == 3'h0) ? 3'h4 : c);
      end
      wr(GN, 8'hE7);
      smp(P5, P3);
      chk(voltage_gain_code, 3'h4);
      chk(current_gain_code, 3'h4);
      for (int k = 0; k < 8; k++) begin
         s = k[2:1];
         tamper_picks_b <= k[0];
         wr(CS, {2'b00, s, k[1], k[2], 2'b00});
         smp(P5, P3);
         e = (s == 2'h1) ? 1'b0 : (s == 2'h2) ? 1'b1 : k[0];
         chk(tamper_current_input_ind, e);
         chk(voltage_input_ground, k[1]);
         chk(current_inputs_ground, k[2]);
         rd(AM, {e, 7'h00});
      end
      for (int k = 0; k < 6; k++) begin
         wr(AM, md[k]);
         smp(24'(av[k]), 24'(rv[k]));
         smp(24'(av[k]), 24'(rv[k]));
         chk(ta, 24'(ea[k]));
         chk(tr, 24'(er[k]));
      end
      wr(AM, 8'h00);
      smp(P5, P3);
      wr(CL, 8'h07);
      fault_mode <= 1;
      smp(N5, N3);
      rd(ST, 8'h07);
      chk(irq, 1'b0);
      wr(EN, 8'h07);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b1);
      rd(EN, 8'h07);
      wr(CL, 8'h07);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b0);
      wr(AM, 8'h70);
      smp(N5, N3);
      smp(P5, P3);
      fault_mode <= 0;
      rd(ST, 8'h07);
      chk(irq, 1'b1);
      wr(CL, 8'h07);
      fault_mode <= 1;
      smp(N5, N3);
      rd(ST, 8'h00);
      wr(GN, 8'h09);
      wr(AM, 8'h00);
      smp(P5, P3);
      wr(CL, 8'h07);
      smp(N5, N3);
      rd(ST, 8'h00);
      pls(1'b0);
      pls(1'b1);
      rd(ST, 8'h03);
      summarize();
   end
endmodule
